// ==== design/mrr_defines.vh ====
// register map, field layout and reset constants of the magnetometer result readout
`ifndef MRR_DEFINES_VH
`define MRR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MRR_X_FIELD_LOW            8'h42
`define MRR_X_FIELD_HIGH           8'h43
`define MRR_Y_FIELD_LOW            8'h44
`define MRR_Y_FIELD_HIGH           8'h45
`define MRR_Z_FIELD_LOW            8'h46
`define MRR_Z_FIELD_HIGH           8'h47
`define MRR_RESISTANCE_LOW_READY   8'h48
`define MRR_RESISTANCE_HIGH        8'h49
`define MRR_INTERRUPT_FLAGS        8'h4A

// ----------------------------------------------------------------
// widths and field layout
// ----------------------------------------------------------------
`define MRR_ADDR_W                 8
`define MRR_DATA_W                 8
`define MRR_XY_W                   13
`define MRR_Z_W                    15
`define MRR_RES_W                  14
`define MRR_XY_LOW_BITS            5
`define MRR_Z_LOW_BITS             7
`define MRR_RES_LOW_BITS           6
`define MRR_FLAG_COUNT             8
`define MRR_FLAG_OVERRUN           7
`define MRR_FLAG_OVERFLOW          6
`define MRR_EVENT_W                7
`define MRR_XY_PAD                 2'h0
`define MRR_RES_PAD                1'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MRR_SELFCHECK_RESET        1'h1
`define MRR_FLAG_RESET             1'h0
`define MRR_BYTE_ZERO              8'h00

`endif

// ==== design/mrr_field_hold.v ====
// one measured result held for the host, with a read-coherent copy
`timescale 1ns/100ps
`include "mrr_defines.vh"

module mrr_field_hold #(
  parameter W = 13
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         load,
  input  wire         force_zero,
  input  wire         freeze,
  input  wire [W-1:0] din,
  output wire [W-1:0] shown
);

  reg [W-1:0] live_reg;
  reg [W-1:0] live_next;
  reg [W-1:0] shown_reg;

  // ----------------------------------------------------------------
  // latest result: a disabled channel simply never loads, so it keeps
  // its last value; force_zero wins over a load for the resistance
  // ----------------------------------------------------------------
  always @* begin
    live_next = live_reg;
    if (force_zero) begin
      live_next = {W{1'b0}};
    end else if (load) begin
      live_next = din;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      live_reg <= {W{1'b0}};
    end else begin
      live_reg <= live_next;
    end
  end

  // ----------------------------------------------------------------
  // host copy: held while a burst runs so low and high halves match;
  // a result that lands mid-burst shows once the burst ends
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shown_reg <= {W{1'b0}};
    end else if (!freeze) begin
      shown_reg <= live_reg;
    end
  end

  assign shown = shown_reg;

endmodule

// ==== design/mrr_sticky_flag.v ====
// one status flag that hardware sets and a read clears, set winning
`timescale 1ns/100ps
`include "mrr_defines.vh"

module mrr_sticky_flag (
  input  wire clk,
  input  wire rst,
  input  wire set,
  input  wire clear,
  output wire flag
);

  reg flag_reg;
  reg flag_next;

  // ----------------------------------------------------------------
  // a set in the clearing cycle must not be lost, so set is tested last
  // ----------------------------------------------------------------
  always @* begin
    flag_next = flag_reg;
    if (clear) begin
      flag_next = 1'b0;
    end
    if (set) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= `MRR_FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule

// ==== design/mrr_readout.v ====
// result and status register group of a three-axis magnetic sensor
`timescale 1ns/100ps
`include "mrr_defines.vh"

// What this block does
// RQ1: x field, 13 bits: bits 4..0 at low[7:3], 12..5 in high; low[2:1] zero.
// RQ2: x self-check result in low x register bit 0, one after reset.
// RQ3: y field, 13 bits: bits 4..0 at low[7:3], 12..5 in high; low[2:1] zero.
// RQ4: y self-check result in low y register bit 0, one after reset.
// RQ5: z field, 15 bits: bits 6..0 at low[7:1], 14..7 in high register.
// RQ6: z self-check result in low z register bit 0, one after reset.
// RQ7: resistance, 14 bits: bits 5..0 at low[7:2], 13..6 in high; low[1] zero.
// RQ8: new-result flag shown in bit 0 of the low resistance register.
// RQ9: interrupt flags register: overrun in bit 7, overflow in bit 6.
// RQ10: high-threshold flags: z bit 5, y bit 4, x bit 3.
// RQ11: low-threshold flags: z bit 2, y bit 1, x bit 0.
// RQ12: a disabled channel keeps its last field result unchanged.
// RQ13: z disabled stops resistance and forces its field bits to read zero; low[0] still shows the new-result flag.
// RQ14: host reads both halves in one burst; halves are latched coherently.
module mrr_readout (
  input  wire                      CORE_CLK,
  input  wire                      RST,
  input  wire                      RD_EN,
  input  wire [`MRR_ADDR_W-1:0]    RD_ADDR,
  input  wire                      RD_BURST,
  output wire [`MRR_DATA_W-1:0]    RD_DATA,
  output wire                      RD_VALID,
  input  wire                      MEAS_VALID,
  input  wire [`MRR_XY_W-1:0]      MEAS_X,
  input  wire [`MRR_XY_W-1:0]      MEAS_Y,
  input  wire [`MRR_Z_W-1:0]       MEAS_Z,
  input  wire [`MRR_RES_W-1:0]     MEAS_RES,
  input  wire                      CHAN_X_EN,
  input  wire                      CHAN_Y_EN,
  input  wire                      CHAN_Z_EN,
  input  wire                      SELFCHECK_VALID,
  input  wire                      SELFCHECK_X,
  input  wire                      SELFCHECK_Y,
  input  wire                      SELFCHECK_Z,
  input  wire                      OVERRUN_EN,
  input  wire [`MRR_EVENT_W-1:0]   FLAG_EVENTS,
  output wire                      NEW_RESULT
);

  // ----------------------------------------------------------------
  // address decode helper
  // ----------------------------------------------------------------
  function hit;
    input                   en;
    input [`MRR_ADDR_W-1:0] addr;
    input [`MRR_ADDR_W-1:0] target;
    begin
      hit = en && (addr == target);
    end
  endfunction

  wire [`MRR_XY_W-1:0]  x_field;
  wire [`MRR_XY_W-1:0]  y_field;
  wire [`MRR_Z_W-1:0]   z_field;
  wire [`MRR_RES_W-1:0] res_field;
  wire [`MRR_FLAG_COUNT-1:0] flags;
  wire                  new_result_flag;
  wire                  read_flags;
  wire                  read_res_high;
  wire                  overrun_set;
  wire [`MRR_FLAG_COUNT-1:0] flag_set;

  reg                   x_selfcheck_result_reg;
  reg                   y_selfcheck_result_reg;
  reg                   z_selfcheck_result_reg;
  reg [`MRR_DATA_W-1:0] rd_data_reg;
  reg [`MRR_DATA_W-1:0] rd_data_next;
  reg                   rd_valid_reg;
  reg [`MRR_DATA_W-1:0] x_field_low_bits;
  reg [`MRR_DATA_W-1:0] x_field_high_bits;
  reg [`MRR_DATA_W-1:0] y_field_low_bits;
  reg [`MRR_DATA_W-1:0] y_field_high_bits;
  reg [`MRR_DATA_W-1:0] z_field_low_bits;
  reg [`MRR_DATA_W-1:0] z_field_high_bits;
  reg [`MRR_DATA_W-1:0] resistance_low_bits;
  reg [`MRR_DATA_W-1:0] resistance_high_bits;

  // ----------------------------------------------------------------
  // field holders: each axis loads only while its channel is enabled
  // ----------------------------------------------------------------
  mrr_field_hold #(
    .W          (`MRR_XY_W)
  ) u_x_hold (
    .clk        (CORE_CLK),
    .rst        (RST),
    .load       (MEAS_VALID && CHAN_X_EN),  // [RQ12]
    .force_zero (1'b0),
    .freeze     (RD_BURST),                 // [RQ14]
    .din        (MEAS_X),
    .shown      (x_field)
  );

  mrr_field_hold #(
    .W          (`MRR_XY_W)
  ) u_y_hold (
    .clk        (CORE_CLK),
    .rst        (RST),
    .load       (MEAS_VALID && CHAN_Y_EN),  // [RQ12]
    .force_zero (1'b0),
    .freeze     (RD_BURST),                 // [RQ14]
    .din        (MEAS_Y),
    .shown      (y_field)
  );

  mrr_field_hold #(
    .W          (`MRR_Z_W)
  ) u_z_hold (
    .clk        (CORE_CLK),
    .rst        (RST),
    .load       (MEAS_VALID && CHAN_Z_EN),  // [RQ12]
    .force_zero (1'b0),
    .freeze     (RD_BURST),                 // [RQ14]
    .din        (MEAS_Z),
    .shown      (z_field)
  );

  // the resistance is measured with z, so it dies with the z channel
  mrr_field_hold #(
    .W          (`MRR_RES_W)
  ) u_res_hold (
    .clk        (CORE_CLK),
    .rst        (RST),
    .load       (MEAS_VALID),
    .force_zero (!CHAN_Z_EN),               // [RQ13]
    .freeze     (RD_BURST),                 // [RQ14]
    .din        (MEAS_RES),
    .shown      (res_field)
  );

  // ----------------------------------------------------------------
  // self-check results: they read one until a self-check reports
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      x_selfcheck_result_reg <= `MRR_SELFCHECK_RESET;  // [RQ2]
      y_selfcheck_result_reg <= `MRR_SELFCHECK_RESET;  // [RQ4]
      z_selfcheck_result_reg <= `MRR_SELFCHECK_RESET;  // [RQ6]
    end else if (SELFCHECK_VALID) begin
      x_selfcheck_result_reg <= SELFCHECK_X;
      y_selfcheck_result_reg <= SELFCHECK_Y;
      z_selfcheck_result_reg <= SELFCHECK_Z;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  assign read_flags    = hit(RD_EN, RD_ADDR, `MRR_INTERRUPT_FLAGS);
  assign read_res_high = hit(RD_EN, RD_ADDR, `MRR_RESISTANCE_HIGH);

  // a fresh result while the last one is still unread is an overrun
  assign overrun_set = MEAS_VALID && new_result_flag && OVERRUN_EN;

  // overrun is built here; the threshold and overflow events come in
  assign flag_set = {overrun_set, FLAG_EVENTS};  // [RQ9] [RQ10] [RQ11]

  // new result: set by each measurement, cleared by any read of the high
  // resistance byte, such as the one that ends the low-high burst
  mrr_sticky_flag u_new_result (
    .clk   (CORE_CLK),
    .rst   (RST),
    .set   (MEAS_VALID),
    .clear (read_res_high),
    .flag  (new_result_flag)
  );

  // interrupt flags are sticky and cleared by reading their register
  genvar gi;
  generate
    for (gi = 0; gi < `MRR_FLAG_COUNT; gi = gi + 1) begin : g_flag
      mrr_sticky_flag u_flag (
        .clk   (CORE_CLK),
        .rst   (RST),
        .set   (flag_set[gi]),
        .clear (read_flags),
        .flag  (flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // byte packing of each result
  // ----------------------------------------------------------------
  always @* begin
    x_field_low_bits     = {x_field[`MRR_XY_LOW_BITS-1:0], `MRR_XY_PAD,
                            x_selfcheck_result_reg};                   // [RQ1] [RQ2]
    x_field_high_bits    = x_field[`MRR_XY_W-1:`MRR_XY_LOW_BITS];      // [RQ1]
    y_field_low_bits     = {y_field[`MRR_XY_LOW_BITS-1:0], `MRR_XY_PAD,
                            y_selfcheck_result_reg};                   // [RQ3] [RQ4]
    y_field_high_bits    = y_field[`MRR_XY_W-1:`MRR_XY_LOW_BITS];      // [RQ3]
    z_field_low_bits     = {z_field[`MRR_Z_LOW_BITS-1:0],
                            z_selfcheck_result_reg};                   // [RQ5] [RQ6]
    z_field_high_bits    = z_field[`MRR_Z_W-1:`MRR_Z_LOW_BITS];        // [RQ5]
    resistance_low_bits  = {res_field[`MRR_RES_LOW_BITS-1:0], `MRR_RES_PAD,
                            new_result_flag};                          // [RQ7] [RQ8]
    resistance_high_bits = res_field[`MRR_RES_W-1:`MRR_RES_LOW_BITS];  // [RQ7]
  end

  // ----------------------------------------------------------------
  // read port: data one cycle after the request, zero when unmapped
  // ----------------------------------------------------------------
  always @* begin
    case (RD_ADDR)
      `MRR_X_FIELD_LOW:          rd_data_next = x_field_low_bits;
      `MRR_X_FIELD_HIGH:         rd_data_next = x_field_high_bits;
      `MRR_Y_FIELD_LOW:          rd_data_next = y_field_low_bits;
      `MRR_Y_FIELD_HIGH:         rd_data_next = y_field_high_bits;
      `MRR_Z_FIELD_LOW:          rd_data_next = z_field_low_bits;
      `MRR_Z_FIELD_HIGH:         rd_data_next = z_field_high_bits;
      `MRR_RESISTANCE_LOW_READY: rd_data_next = resistance_low_bits;
      `MRR_RESISTANCE_HIGH:      rd_data_next = resistance_high_bits;
      `MRR_INTERRUPT_FLAGS:      rd_data_next = flags;  // [RQ9] [RQ10] [RQ11]
      default:                   rd_data_next = `MRR_BYTE_ZERO;
    endcase
  end

  // data stays until the next read so a slow host may sample it late
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_data_reg  <= `MRR_BYTE_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= RD_EN;
      if (RD_EN) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  assign RD_DATA    = rd_data_reg;
  assign RD_VALID   = rd_valid_reg;
  assign NEW_RESULT = new_result_flag;

endmodule

// ==== verif/mrr_readout_monitor.sv ====
// port-level assertions for the magnetometer result readout
`timescale 1ns/100ps
module mrr_readout_monitor (
  input wire       CORE_CLK,
  input wire       RST,
  input wire       RD_EN,
  input wire [7:0] RD_ADDR,
  input wire       RD_BURST,
  input wire [7:0] RD_DATA,
  input wire       RD_VALID,
  input wire       MEAS_VALID,
  input wire       CHAN_Z_EN,
  input wire [6:0] FLAG_EVENTS,
  input wire       NEW_RESULT
);
  // ----------------------------------------------------------------
  // read port and field layout
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_valid; RD_EN |=> RD_VALID; endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  property p_unmapped; RD_EN && (RD_ADDR < 8'h42 || RD_ADDR > 8'h4A) |=> RD_DATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_xpad; RD_EN && RD_ADDR == 8'h42 |=> RD_DATA[2:1] == 2'h0; endproperty
  a_xpad: assert property (p_xpad) else $error("x low pad bits set");
  property p_ypad; RD_EN && RD_ADDR == 8'h44 |=> RD_DATA[2:1] == 2'h0; endproperty
  a_ypad: assert property (p_ypad) else $error("y low pad bits set");
  property p_rpad; RD_EN && RD_ADDR == 8'h48 |=> !RD_DATA[1]; endproperty
  a_rpad: assert property (p_rpad) else $error("resistance pad bit set");
  // zero forcing reaches the host copy two edges after z drops (live, then shown),
  // so only a read taken once z has been off three edges is judged
  property p_zres; RD_EN && RD_ADDR[7:1] == 7'h24 && !CHAN_Z_EN && !$past(CHAN_Z_EN)
    && !$past(CHAN_Z_EN, 2) && !$past(RD_BURST)
    |=> RD_DATA[7:1] == 7'h00 && (RD_DATA[0] == 1'h0 || $past(RD_ADDR) == 8'h48); endproperty
  a_zres: assert property (p_zres) else $error("resistance not zero");
  property p_newres; MEAS_VALID |=> NEW_RESULT; endproperty
  a_newres: assert property (p_newres) else $error("new result not flagged");
  property p_ready; RD_EN && RD_ADDR == 8'h48 |=> RD_DATA[0] == $past(NEW_RESULT); endproperty
  a_ready: assert property (p_ready) else $error("ready bit mismatch");
  // ----------------------------------------------------------------
  // status flags seen one edge after their event
  // ----------------------------------------------------------------
  property p_lowx; FLAG_EVENTS[0] ##1 RD_EN && RD_ADDR == 8'h4A |=> RD_DATA[0]; endproperty
  a_lowx: assert property (p_lowx) else $error("low x flag lost");
  property p_highz; FLAG_EVENTS[5] ##1 RD_EN && RD_ADDR == 8'h4A |=> RD_DATA[5]; endproperty
  a_highz: assert property (p_highz) else $error("high z flag lost");
  property p_ovf; FLAG_EVENTS[6] ##1 RD_EN && RD_ADDR == 8'h4A |=> RD_DATA[6]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag lost");
  c_burst: cover property (RD_BURST && MEAS_VALID);
  c_zoff: cover property (MEAS_VALID && !CHAN_Z_EN);
  c_flag: cover property (RD_EN && RD_ADDR == 8'h4A ##1 RD_DATA != 8'h00);
endmodule
bind mrr_readout mrr_readout_monitor u_mon (.CORE_CLK, .RST, .RD_EN, .RD_ADDR, .RD_BURST,
  .RD_DATA, .RD_VALID, .MEAS_VALID, .CHAN_Z_EN, .FLAG_EVENTS, .NEW_RESULT);

// ==== verif/mrr_host_model.sv ====
// host side of the register read port
`timescale 1ns/100ps
module mrr_host_model (
  input wire       CORE_CLK,
  input wire [7:0] RD_DATA,
  output reg       RD_EN,
  output reg [7:0] RD_ADDR,
  output reg       RD_BURST
);
  initial begin
    RD_EN = 1'h0;
    RD_ADDR = 8'hFF;
    RD_BURST = 1'h0;
  end
  // single byte; address is scrambled once released so a stale value never reads back
  task rd(input [7:0] a, output [7:0] d);
    @(posedge CORE_CLK) begin RD_EN <= 1'h1; RD_ADDR <= a; end
    @(posedge CORE_CLK) begin RD_EN <= 1'h0; RD_ADDR <= ~a; end
    #1 d = RD_DATA;
  endtask
  // low then high byte under one burst so both halves belong together
  task pair(input [7:0] a, output [7:0] lo, output [7:0] hi);
    @(posedge CORE_CLK) begin RD_BURST <= 1'h1; RD_EN <= 1'h1; RD_ADDR <= a; end
    @(posedge CORE_CLK) RD_ADDR <= a + 8'h01;
    #1 lo = RD_DATA;
    @(posedge CORE_CLK) begin RD_EN <= 1'h0; RD_BURST <= 1'h0; RD_ADDR <= ~a; end
    #1 hi = RD_DATA;
  endtask
endmodule

// ==== verif/test_mrr_readout.sv ====
// self-checking bench of the magnetometer result readout
`timescale 1ns/100ps
module test_mrr_readout;
  reg CORE_CLK, RST, MEAS_VALID, CX, CY, CZ, SV, SX, SY, SZ, OVERRUN_EN;
  reg [12:0] MX, MY;
  reg [14:0] MZ;
  reg [13:0] MR;
  reg [6:0] FLAG_EVENTS;
  wire [7:0] RD_ADDR, RD_DATA;
  wire RD_EN, RD_BURST, RD_VALID, NEW_RESULT;
  reg [7:0] lo, hi, d;
  integer fail_count = 0, n_checks = 0, i;
  mrr_readout uut (.CORE_CLK, .RST, .RD_EN, .RD_ADDR, .RD_BURST, .RD_DATA, .RD_VALID,
    .MEAS_VALID, .MEAS_X(MX), .MEAS_Y(MY), .MEAS_Z(MZ), .MEAS_RES(MR), .CHAN_X_EN(CX),
    .CHAN_Y_EN(CY), .CHAN_Z_EN(CZ), .SELFCHECK_VALID(SV), .SELFCHECK_X(SX),
    .SELFCHECK_Y(SY), .SELFCHECK_Z(SZ), .OVERRUN_EN, .FLAG_EVENTS, .NEW_RESULT);
  mrr_host_model host (.CORE_CLK, .RD_DATA, .RD_EN, .RD_ADDR, .RD_BURST);
  // expected {high, low} images of each result pair
  function [15:0] fxy(input [12:0] v, input s); fxy = {v[12:5], v[4:0], 2'h0, s}; endfunction
  function [15:0] fz(input [14:0] v, input s); fz = {v[14:7], v[6:0], s}; endfunction
  function [15:0] fr(input [13:0] v, input s); fr = {v[13:6], v[5:0], 1'h0, s}; endfunction
  task chk(input string n, input [7:0] e, input [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task pchk(input [7:0] a, input [15:0] e);
    host.pair(a, lo, hi);
    chk("pair low", e[7:0], lo);
    chk("pair high", e[15:8], hi);
  endtask
  task meas(input [12:0] x, input [12:0] y, input [14:0] z, input [13:0] r);
    @(posedge CORE_CLK) begin MEAS_VALID <= 1'h1; MX <= x; MY <= y; MZ <= z; MR <= r; end
    @(posedge CORE_CLK) MEAS_VALID <= 1'h0;
    repeat (2) @(posedge CORE_CLK);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    for (i = 8'h41; i <= 8'h4B; i = i + 1) begin
      host.rd(i, d);
      chk("reset image", (i == 8'h42 || i == 8'h44 || i == 8'h46) ? 8'h01 : 8'h00, d);
    end
    $display("test reset done");
  endtask
  task t_fields;
    meas(13'h1A5B, 13'h0F0F, 15'h5A3C, 14'h2C71);
    chk("new result", 8'h01, {7'h00, NEW_RESULT});
    pchk(8'h42, fxy(13'h1A5B, 1'h1));
    pchk(8'h44, fxy(13'h0F0F, 1'h1));
    pchk(8'h46, fz(15'h5A3C, 1'h1));
    pchk(8'h48, fr(14'h2C71, 1'h1));
    chk("new result cleared", 8'h00, {7'h00, NEW_RESULT});
    $display("test fields done");
  endtask
  task t_disable;
    @(posedge CORE_CLK) begin CX <= 1'h0; CY <= 1'h0; end
    meas(13'h0123, 13'h1FFF, 15'h7FFF, 14'h3FFF);
    pchk(8'h42, fxy(13'h1A5B, 1'h1));
    pchk(8'h44, fxy(13'h0F0F, 1'h1));
    pchk(8'h46, fz(15'h7FFF, 1'h1));
    @(posedge CORE_CLK) CZ <= 1'h0;
    meas(13'h0123, 13'h1FFF, 15'h0001, 14'h3FFF);
    pchk(8'h46, fz(15'h7FFF, 1'h1));
    pchk(8'h48, 16'h0001);
    @(posedge CORE_CLK) begin CX <= 1'h1; CY <= 1'h1; CZ <= 1'h1; end
    $display("test disable done");
  endtask
  task t_self;
    @(posedge CORE_CLK) begin SV <= 1'h1; SX <= 1'h0; SY <= 1'h1; SZ <= 1'h0; end
    @(posedge CORE_CLK) SV <= 1'h0;
    pchk(8'h42, fxy(13'h1A5B, 1'h0));
    pchk(8'h44, fxy(13'h0F0F, 1'h1));
    pchk(8'h46, fz(15'h7FFF, 1'h0));
    $display("test selfcheck done");
  endtask
  // a measurement landing inside a burst must not split the pair
  task t_freeze;
    fork
      pchk(8'h42, fxy(13'h1A5B, 1'h0));
      meas(13'h0123, 13'h0F0F, 15'h7FFF, 14'h2C71);
    join
    repeat (2) @(posedge CORE_CLK);
    pchk(8'h42, fxy(13'h0123, 1'h0));
    $display("test freeze done");
  endtask
  task t_flags;
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge CORE_CLK) FLAG_EVENTS <= 7'h01 << i;
      @(posedge CORE_CLK) FLAG_EVENTS <= 7'h00;
      host.rd(8'h4A, d);
      chk("flag set", 8'h01 << i, d);
      host.rd(8'h4A, d);
      chk("flag cleared", 8'h00, d);
    end
    @(posedge CORE_CLK) OVERRUN_EN <= 1'h1;
    meas(13'h0123, 13'h0F0F, 15'h7FFF, 14'h2C71);
    meas(13'h0123, 13'h0F0F, 15'h7FFF, 14'h2C71);
    host.rd(8'h4A, d);
    chk("overrun", 8'h80, d);
    $display("test flags done");
  endtask
  initial begin
    CORE_CLK = 1'h0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial begin
    RST = 1'h1; MEAS_VALID = 1'h0; MX = 13'h0000; MY = 13'h0000; MZ = 15'h0000;
    MR = 14'h0000; CX = 1'h1; CY = 1'h1; CZ = 1'h1; SV = 1'h0; SX = 1'h1; SY = 1'h1;
    SZ = 1'h1; OVERRUN_EN = 1'h0; FLAG_EVENTS = 7'h00;
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'h0;
    t_reset;
    t_fields;
    t_disable;
    t_self;
    t_freeze;
    t_flags;
    print_verdict;
  end
endmodule
